// >>> rtl/acc_params.svh
// What this block does
// - Load high result; other high bits zero
// - Load low result on every completion not dropped by the lock
// - High read locks results until low read
// - Drop results finishing while lock holds
// - No interlock in 8-bit mode
// - Power bit selects reduced or high speed
// - Divide input clock by 1,2,4,8
// - Select bus or alternate clock source
// - Decode mode field, four settings
// - Reset selects 8-bit write-triggered mode
// - Round result to 8 or 10 bits
// - Sample 23.5 or 3.5 conversion cycles; taken here as 24 or 4 whole cycles
// - Own clock runs only while converting
// - Bus clock source stops in stop mode
// - Control write aborts, restarts unless off or in reserved/external mode
// - Completion flag set, cleared by write/read
// - Continuous stops on clock write, and on stop unless own clock
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
// Register offsets
`define ACC_OFS_SCR 8'h3c
`define ACC_OFS_HIGH 8'h3d
`define ACC_OFS_LOW 8'h3e
`define ACC_OFS_CLK 8'h3f
`define ACC_OFS_ISR 8'h40
`define ACC_OFS_IMR 8'h41
// Control register fields
`define ACC_SCR_CONVERSION_COMPLETE_FLAG 7
`define ACC_SCR_AIEN 6
`define ACC_SCR_CONT 5
`define ACC_CH_OFF 5'h1f
// Clock register fields
`define ACC_CLK_LPC 7
`define ACC_CLK_ICS 4
`define ACC_CLK_LSMP 1
`define ACC_CLK_ACLK 0
// Reset values
`define ACC_SCR_RST 8'h1f
`define ACC_CLK_RST 8'h00
// Sample times in tenths of a conversion cycle
`define ACC_SAMP_SHORT_X10 35
`define ACC_SAMP_LONG_X10 235
`define ACC_SAMP_SHORT_CYC ((`ACC_SAMP_SHORT_X10 + 9) / 10)
`define ACC_SAMP_LONG_CYC ((`ACC_SAMP_LONG_X10 + 9) / 10)
// Conversion steps per width
`define ACC_STEPS8 8
`define ACC_STEPS10 10
`endif

// >>> rtl/acc_pkg.sv
package acc_pkg;
  // Resolution and trigger modes
  typedef enum logic [1:0] {
    ACC_M8_WRITE  = 2'b00,
    ACC_M10_WRITE = 2'b01,
    ACC_M_RSVD    = 2'b10,
    ACC_M10_EXT   = 2'b11
  } acc_mode_t;
  // Converter sequence
  typedef enum logic [1:0] {
    ACC_IDLE    = 2'b00,
    ACC_SAMPLE  = 2'b01,
    ACC_CONVERT = 2'b10
  } acc_phase_t;
  // All state of the block
  typedef struct packed {
    logic [4:0]  ch;
    logic        cont;
    logic        aien;
    logic        conversion_complete_flag;
    logic [7:0]  clk;
    logic [9:0]  res;
    logic        lock;
    acc_phase_t  ph;
    logic [4:0]  cnt;
    logic [2:0]  dcnt;
    logic [7:0]  acnt;
    logic [11:0] raw;
    logic [1:0]  isr;
    logic [1:0]  imr;
    logic [7:0]  rdata;
    logic        irq;
    logic        busy;
    logic        aact;
    logic        samp;
  } acc_st_t;
endpackage

// >>> rtl/acc_top.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_top #(
  parameter logic [7:0] ASYNC_DIV = 8'h04
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output      logic [7:0]  RDATA,
  input  wire logic [11:0] ANALOG_CODE,
  input  wire logic        ALT_CLK_TICK,
  input  wire logic        EXT_TRIGGER,
  input  wire logic        STOP_MODE,
  output      logic [4:0]  CHANNEL,
  output      logic        SAMPLE,
  output      logic        BUSY,
  output      logic        LOW_POWER,
  output      logic        ASYNC_ACTIVE,
  output      logic        IRQ
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  acc_pkg::acc_st_t   q;      // Registered state
  acc_pkg::acc_st_t   d;      // Next state
  acc_pkg::acc_mode_t mode;   // Current mode field
  logic        ten;           // Ten-bit operation
  logic        wr_scr;        // Control register write
  logic        wr_clk;        // Clock register write
  logic        wr_isr;        // Status clear write
  logic        wr_imr;        // Mask write
  logic        rd_high;       // High result read
  logic        rd_low;        // Low result read
  logic        aon;           // Own clock generator running
  logic        atick;         // Own clock edge
  logic        src;           // Input clock edge
  logic        ctick;         // Conversion clock edge
  logic [2:0]  dlast;         // Divider terminal count
  logic [4:0]  slast;         // Last sample cycle
  logic [4:0]  blast;         // Last conversion step
  logic [12:0] sum10;         // Rounding sum, 10 bits
  logic [12:0] sum8;          // Rounding sum, 8 bits
  logic [9:0]  rnd;           // Rounded result
  logic        done;          // Conversion finished
  logic        drop;          // Finished result lost
  logic        ch_on;         // Channel not the off code
  logic [1:0]  ev;            // Events this cycle

  ////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  assign RDATA        = q.rdata;
  assign CHANNEL      = q.ch;
  assign SAMPLE       = q.samp;
  assign BUSY         = q.busy;
  assign LOW_POWER    = q.clk[`ACC_CLK_LPC];
  assign ASYNC_ACTIVE = q.aact;
  assign IRQ          = q.irq;

  ////////////////////////////////////////////////////////////////////
  // Bus decode

  // One strobe at a time, so a plain chain suffices
  always_comb begin
    wr_scr  = 1'b0;
    wr_clk  = 1'b0;
    wr_isr  = 1'b0;
    wr_imr  = 1'b0;
    rd_high = 1'b0;
    rd_low  = 1'b0;
    if (WR && ADDR == `ACC_OFS_SCR) begin
      wr_scr = 1'b1;
    end else if (WR && ADDR == `ACC_OFS_CLK) begin
      wr_clk = 1'b1;
    end else if (WR && ADDR == `ACC_OFS_ISR) begin
      wr_isr = 1'b1;
    end else if (WR && ADDR == `ACC_OFS_IMR) begin
      wr_imr = 1'b1;
    end else if (RD && ADDR == `ACC_OFS_HIGH) begin
      rd_high = 1'b1;
    end else if (RD && ADDR == `ACC_OFS_LOW) begin
      rd_low = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Clock selection and division

  always_comb begin
    mode = acc_pkg::acc_mode_t'(q.clk[3:2]);
    // Reserved mode counts as ten-bit for steps, rounding, storage and interlock
    ten  = (mode != acc_pkg::ACC_M8_WRITE);
    // Own generator stays idle between conversions to save power
    aon   = q.clk[`ACC_CLK_ACLK] && q.busy;
    atick = aon && (q.acnt == 8'(ASYNC_DIV - 8'h01));
    // Bus clock gives an edge every cycle
    if (q.clk[`ACC_CLK_ACLK]) begin
      src = atick;
    end else if (q.clk[`ACC_CLK_ICS]) begin
      src = 1'b1;
    end else begin
      src = ALT_CLK_TICK;
    end
    dlast = 3'((4'h1 << q.clk[6:5]) - 4'h1);
    ctick = src && (q.dcnt == dlast);
    // Half cycle rounded up: only whole edges are seen here
    if (q.clk[`ACC_CLK_LSMP]) begin
      slast = 5'(`ACC_SAMP_LONG_CYC - 1);
    end else begin
      slast = 5'(`ACC_SAMP_SHORT_CYC - 1);
    end
    blast = ten ? 5'(`ACC_STEPS10 - 1) : 5'(`ACC_STEPS8 - 1);
    ch_on = (q.ch != `ACC_CH_OFF);
  end

  ////////////////////////////////////////////////////////////////////
  // Rounding of the raw code

  // Half an output step is added, then truncated; top code saturates
  always_comb begin
    sum10 = {1'b0, q.raw} + 13'h0002;
    sum8  = {1'b0, q.raw} + 13'h0008;
    if (!ten) begin
      rnd = sum8[12] ? 10'h0ff : {2'b00, sum8[11:4]};
    end else begin
      rnd = sum10[12] ? 10'h3ff : sum10[11:2];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d    = q;
    done = 1'b0;
    drop = 1'b0;
    // Own clock prescaler
    if (aon) begin
      d.acnt = atick ? 8'h00 : 8'(q.acnt + 8'h01);
    end else begin
      d.acnt = 8'h00;
    end
    // Conversion clock divider, reset while idle
    if (!q.busy) begin
      d.dcnt = 3'h0;
    end else if (src) begin
      d.dcnt = ctick ? 3'h0 : 3'(q.dcnt + 3'h1);
    end
    // Sample then approximate
    case (q.ph)
      acc_pkg::ACC_IDLE: begin
        d.cnt = 5'h00;
      end
      acc_pkg::ACC_SAMPLE: begin
        if (ctick && q.cnt == slast) begin
          d.raw = ANALOG_CODE;
          d.ph  = acc_pkg::ACC_CONVERT;
          d.cnt = 5'h00;
        end else if (ctick) begin
          d.cnt = 5'(q.cnt + 5'h01);
        end
      end
      acc_pkg::ACC_CONVERT: begin
        if (ctick && q.cnt == blast) begin
          done = 1'b1;
        end else if (ctick) begin
          d.cnt = 5'(q.cnt + 5'h01);
        end
      end
      default: begin
        d.ph = acc_pkg::ACC_IDLE;
      end
    endcase
    // Completion: store unless the interlock holds
    if (done) begin
      if (q.lock && ten) begin
        drop = 1'b1;
      end else begin
        d.res = rnd;
      end
      d.cnt = 5'h00;
      d.ph  = q.cont ? acc_pkg::ACC_SAMPLE : acc_pkg::ACC_IDLE;
    end
    // Interlock: armed by high read in ten-bit mode only
    if (rd_high && ten) begin
      d.lock = 1'b1;
    end else if (rd_low || !ten) begin
      d.lock = 1'b0;
    end
    // Control write aborts whatever runs
    if (wr_scr) begin
      d.ch   = WDATA[4:0];
      d.cont = WDATA[`ACC_SCR_CONT];
      d.aien = WDATA[`ACC_SCR_AIEN];
      d.cnt  = 5'h00;
      if (WDATA[4:0] != `ACC_CH_OFF && !mode[1]) begin
        d.ph = acc_pkg::ACC_SAMPLE;
      end else begin
        d.ph = acc_pkg::ACC_IDLE;
      end
    end else if (mode == acc_pkg::ACC_M10_EXT && q.ph == acc_pkg::ACC_IDLE
                 && EXT_TRIGGER && ch_on) begin
      d.ph  = acc_pkg::ACC_SAMPLE;
      d.cnt = 5'h00;
    end
    // Clock write ends continuous running
    if (wr_clk) begin
      d.clk  = WDATA;
      d.cont = 1'b0;
    end
    // Stop mode halts a bus or alternate clocked conversion
    if (STOP_MODE && !q.clk[`ACC_CLK_ACLK]) begin
      d.ph   = acc_pkg::ACC_IDLE;
      d.cont = 1'b0;
      d.cnt  = 5'h00;
    end
    // Completion flag, a new completion wins over a clear
    d.conversion_complete_flag = done || (q.conversion_complete_flag && !(wr_scr || rd_low));
    // Sticky events: bit 0 done, bit 1 result dropped
    ev    = {drop, done};
    d.isr = ev | (q.isr & ~(wr_isr ? WDATA[1:0] : 2'b00));
    if (wr_imr) begin
      d.imr = WDATA[1:0];
    end
    // Read data for the next cycle only
    d.rdata = 8'h00;
    if (RD && ADDR == `ACC_OFS_SCR) begin
      d.rdata = {q.conversion_complete_flag, q.aien, q.cont, q.ch};
    end else if (rd_high) begin
      d.rdata = ten ? {6'h00, q.res[9:8]} : 8'h00;
    end else if (rd_low) begin
      d.rdata = q.res[7:0];
    end else if (RD && ADDR == `ACC_OFS_CLK) begin
      d.rdata = q.clk;
    end else if (RD && ADDR == `ACC_OFS_ISR) begin
      d.rdata = {6'h00, q.isr};
    end else if (RD && ADDR == `ACC_OFS_IMR) begin
      d.rdata = {6'h00, q.imr};
    end
    // Flopped status outputs
    d.busy = (d.ph != acc_pkg::ACC_IDLE);
    d.aact = d.busy && d.clk[`ACC_CLK_ACLK];
    d.samp = (d.ph == acc_pkg::ACC_SAMPLE);
    d.irq  = |(d.isr & d.imr);
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      q       <= '0;
      q.ch    <= 5'(`ACC_SCR_RST); // Channel field only: the off code
      q.clk   <= `ACC_CLK_RST;
      q.ph    <= acc_pkg::ACC_IDLE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // Reset leaves the eight-bit write-triggered mode
  // Written without a history function so the first edge has a defined view
  reset_mode_a: assert property (disable iff (1'b0)
    RST |=> q.clk[3:2] == 2'b00)
    else $error("Mode not eight-bit after reset");

  // Flag follows each completion
  conversion_complete_flag_set_a: assert property (
    done |=> q.conversion_complete_flag && q.isr[0])
    else $error("Completion flag not set");

  // Flag cleared by a write or low read without a completion
  conversion_complete_flag_clr_a: assert property (
    (wr_scr || rd_low) && !done |=> !q.conversion_complete_flag)
    else $error("Completion flag not cleared");

  // High register upper bits read zero
  high_zero_a: assert property (
    rd_high |=> RDATA[7:2] == 6'h00 && (ten || RDATA == 8'h00))
    else $error("High result upper bits nonzero");

  // Locked result does not move
  lock_hold_a: assert property (
    q.lock && ten && done && !wr_clk |=> $stable(q.res) && q.isr[1])
    else $error("Result moved under interlock");

  // High read then completion before low read keeps old value
  lock_seq_a: assert property (
    rd_high && ten && !wr_clk ##1 (done && !rd_low) |=> $stable(q.res))
    else $error("Interlock did not hold");

  // Eight-bit completions always update
  nolock8_a: assert property (
    done && !ten |=> q.res == $past(rnd) && q.res[9:8] == 2'b00)
    else $error("Eight-bit result not updated");

  // Low register returns stored low bits
  low_read_a: assert property (
    rd_low |=> RDATA == $past(q.res[7:0]))
    else $error("Low result read wrong");

  // Write with a live channel starts sampling
  start_a: assert property (
    wr_scr && WDATA[4:0] != `ACC_CH_OFF && !mode[1] && !STOP_MODE
    |=> q.ph == acc_pkg::ACC_SAMPLE && q.cnt == 5'h00 && SAMPLE)
    else $error("Control write did not restart");

  // Off code leaves the converter idle
  ch_off_a: assert property (
    wr_scr && WDATA[4:0] == `ACC_CH_OFF |=> !BUSY [*2])
    else $error("Converter ran with channel off");

  // Sample length by sample select
  sample_len_a: assert property (
    q.ph == acc_pkg::ACC_SAMPLE && d.ph == acc_pkg::ACC_CONVERT
    |-> q.cnt == (q.clk[`ACC_CLK_LSMP] ? 5'd23 : 5'd3))
    else $error("Sample length wrong");

  // Divide by two on bus clock: edges alternate
  div_two_a: assert property (
    ctick && q.clk[6:4] == 3'b011 && !q.clk[`ACC_CLK_ACLK] && q.busy
    && $stable(q.clk) |=> !ctick)
    else $error("Divider by two wrong");

  // Stop mode without own clock ends conversions
  stop_a: assert property (
    STOP_MODE && !q.clk[`ACC_CLK_ACLK] |=> !BUSY && !q.cont)
    else $error("Conversion kept running in stop");

  // Clock register write ends continuous running
  clk_wr_a: assert property (
    wr_clk |=> !q.cont)
    else $error("Continuous not ended by clock write");

  // Own clock runs only while converting
  async_a: assert property (
    ASYNC_ACTIVE |-> BUSY && q.clk[`ACC_CLK_ACLK] && !(aon && !q.busy))
    else $error("Own clock active while idle");

  // Eight-bit operation never keeps the interlock armed
  eight_free_a: assert property (
    !ten |=> !q.lock)
    else $error("Interlock held in eight-bit mode");

  // A control write without the continuous bit ends continuous running
  cont_stop_a: assert property (
    wr_scr && !WDATA[`ACC_SCR_CONT] |=> !q.cont)
    else $error("Continuous not ended by control write");

  // An unlocked completion always lands in the result
  res_load_a: assert property (
    done && !(q.lock && ten) |=> q.res == $past(rnd))
    else $error("Completed result not stored");

  // External start in idle begins sampling
  ext_trig_a: assert property (
    mode == acc_pkg::ACC_M10_EXT && q.ph == acc_pkg::ACC_IDLE && EXT_TRIGGER && ch_on
    && !wr_scr && !(STOP_MODE && !q.clk[`ACC_CLK_ACLK]) |=> SAMPLE)
    else $error("External start ignored");

  // Reserved mode never starts a conversion from a write
  rsvd_idle_a: assert property (
    wr_scr && mode == acc_pkg::ACC_M_RSVD |=> !BUSY)
    else $error("Reserved mode started a conversion");

  // Read data stand only in the cycle after a read
  rdata_idle_a: assert property (
    !RD |=> RDATA == 8'h00)
    else $error("Read data outside a read answer");

endmodule

// >>> testbench/acc_far_model.sv
`timescale 1ns/1ps
// Far side stand-in: analog code, alternate clock ticks, start pulse
module acc_far_model #(
  parameter int TICK_DIV = 3 // Alternate clock period in bus clocks
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic [11:0] level,
  input  wire logic        fire,
  output      logic [11:0] ANALOG_CODE  = 12'h000,
  output      logic        ALT_CLK_TICK = 1'b0,
  output      logic        EXT_TRIGGER  = 1'b0
);
  int cnt_q = 0; // Tick prescaler
  //////////////////////////////////////////////////////////////////////////////
  // Slow tick so the alternate source is visibly slower than the bus clock
  always_ff @(posedge REF_CLK) begin
    cnt_q        <= (RST || cnt_q == TICK_DIV - 1) ? 0 : cnt_q + 1;
    ALT_CLK_TICK <= !RST && cnt_q == TICK_DIV - 1;
    ANALOG_CODE  <= level;
    EXT_TRIGGER  <= fire;
  end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        REF_CLK   = 1'b0;    // 40 MHz bus clock
  logic        RST       = 1'b1;    // Sync reset
  logic [7:0]  ADDR      = 8'h00;   // Register address
  logic [7:0]  WDATA     = 8'h00;   // Write data
  logic        WR        = 1'b0;    // Write strobe
  logic        RD        = 1'b0;    // Read strobe
  logic        STOP_MODE = 1'b0;    // Stop mode level
  logic [11:0] level     = 12'h000; // Code the far side presents
  logic        fire      = 1'b0;    // External start request
  logic [7:0]  RDATA;
  logic [11:0] ANALOG_CODE;
  logic [4:0]  CHANNEL;
  logic        ALT_CLK_TICK;
  logic        EXT_TRIGGER;
  logic        SAMPLE;
  logic        BUSY;
  logic        LOW_POWER;
  logic        ASYNC_ACTIVE;
  logic        IRQ;
  int          num_errors = 0;      // Mismatches
  int          compares   = 0;      // Comparisons made
  int          n;                   // Busy length of last conversion
  //////////////////////////////////////////////////////////////////////////////
  // Own generator prescale of 1 keeps the stop mode run short
  acc_top #(.ASYNC_DIV(8'h01)) acc_top_i (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .ANALOG_CODE(ANALOG_CODE),
    .ALT_CLK_TICK(ALT_CLK_TICK), .EXT_TRIGGER(EXT_TRIGGER), .STOP_MODE(STOP_MODE),
    .CHANNEL(CHANNEL), .SAMPLE(SAMPLE), .BUSY(BUSY), .LOW_POWER(LOW_POWER),
    .ASYNC_ACTIVE(ASYNC_ACTIVE), .IRQ(IRQ));
  acc_far_model acc_far_model_i (.REF_CLK(REF_CLK), .RST(RST), .level(level),
    .fire(fire), .ANALOG_CODE(ANALOG_CODE), .ALT_CLK_TICK(ALT_CLK_TICK),
    .EXT_TRIGGER(EXT_TRIGGER));
  initial forever #12.5 REF_CLK = ~REF_CLK;
  //////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic conclude;
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Byte compare, four-state exact
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Cycle count compare within a window
  task automatic chkr(int v, int lo, int hi);
    compares++;
    if (v < lo || v > hi) begin
      num_errors++;
      $display("BAD %0t busy length %0d", $time, v);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // One-cycle bus write
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge REF_CLK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= d;
    @(posedge REF_CLK);
    WR    <= 1'b0;
  endtask
  // One-cycle read; data only stands in the following cycle
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge REF_CLK);
    RD   <= 1'b1;
    ADDR <= a;
    @(posedge REF_CLK);
    RD   <= 1'b0;
    #1 chk(RDATA, e);
  endtask
  // Busy length in cycles; both waits bounded so a dead converter ends
  task automatic run(output int c);
    int w;
    w = 0;
    c = 0;
    #1;
    while (BUSY !== 1'b1 && w < 40) begin
      @(posedge REF_CLK);
      #1 w++;
    end
    while (BUSY === 1'b1 && c < 4000) begin
      @(posedge REF_CLK);
      #1 c++;
    end
  endtask
  // Configure clock, start, and judge the busy span
  task automatic conv(logic [7:0] ck, int lo, int hi);
    wr(8'h3f, ck);
    wr(8'h3c, 8'h03);
    run(n);
    chkr(n, lo, hi);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  task automatic t_reset;
    rd(8'h3f, 8'h00);
    rd(8'h3c, 8'h1f);
    rd(8'h3d, 8'h00);
    chk({7'h00, LOW_POWER}, 8'h00);
  endtask
  // 8-bit: rounding, flag, zero high byte
  task automatic t_eight;
    level <= 12'h7f7;
    conv(8'h10, 12, 12);
    rd(8'h3c, 8'h83);
    rd(8'h3d, 8'h00);
    rd(8'h3e, 8'h7f);
    rd(8'h3c, 8'h03);
    level <= 12'h123;
    conv(8'h10, 12, 12);
    rd(8'h3e, 8'h12);
  endtask
  // Dividers, sample length, clock source, 10-bit layout
  task automatic t_timing;
    int d;
    level <= 12'h9a5;
    for (d = 0; d < 4; d++) begin
      conv({1'b0, d[1:0], 5'b10100}, 13 * (1 << d) + 1, 15 * (1 << d) - 1);
    end
    conv(8'h16, 34, 34);
    conv(8'h04, 40, 44);
    rd(8'h3d, 8'h02);
    rd(8'h3e, 8'h69);
  endtask
  // Interlock drop, continuous stop, interrupt status and mask
  task automatic t_lock;
    wr(8'h3f, 8'h14);
    wr(8'h3c, 8'h23);
    // High read lands one cycle before the second completion
    repeat (25) @(posedge REF_CLK);
    rd(8'h3d, 8'h02);
    level <= 12'h4c6;
    repeat (30) @(posedge REF_CLK);
    rd(8'h3e, 8'h69);
    wr(8'h3f, 8'h14);
    repeat (20) @(posedge REF_CLK);
    #1 chk({7'h00, BUSY}, 8'h00);
    rd(8'h3d, 8'h01);
    rd(8'h3e, 8'h32);
    rd(8'h3c, 8'h03);
    rd(8'h40, 8'h03);
    chk({7'h00, IRQ}, 8'h00);
    wr(8'h41, 8'h01);
    repeat (2) @(posedge REF_CLK);
    #1 chk({7'h00, IRQ}, 8'h01);
    wr(8'h40, 8'h01);
    repeat (2) @(posedge REF_CLK);
    #1 chk({7'h00, IRQ}, 8'h00);
  endtask
  // Trigger modes, abort, channel off, stop mode, own clock
  task automatic t_modes;
    wr(8'h3f, 8'h1c);
    wr(8'h3c, 8'h03);
    repeat (5) @(posedge REF_CLK);
    #1 chk({7'h00, BUSY}, 8'h00);
    fire <= 1'b1;
    @(posedge REF_CLK);
    fire <= 1'b0;
    run(n);
    chkr(n, 14, 14);
    conv(8'h18, 0, 0);
    wr(8'h3f, 8'h14);
    wr(8'h3c, 8'h03);
    repeat (5) @(posedge REF_CLK);
    wr(8'h3c, 8'h03);
    run(n);
    chkr(n, 14, 15);
    wr(8'h3c, 8'h03);
    repeat (3) @(posedge REF_CLK);
    wr(8'h3c, 8'h1f);
    repeat (3) @(posedge REF_CLK);
    #1 chk({7'h00, BUSY}, 8'h00);
    rd(8'h3c, 8'h1f);
    wr(8'h3c, 8'h03);
    STOP_MODE <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    #1 chk({7'h00, BUSY}, 8'h00);
    rd(8'h3c, 8'h03);
    wr(8'h3f, 8'h95);
    wr(8'h3c, 8'h03);
    repeat (3) @(posedge REF_CLK);
    #1 chk({6'h00, LOW_POWER, ASYNC_ACTIVE}, 8'h03);
    run(n);
    chkr(n, 1, 200);
    chk({7'h00, ASYNC_ACTIVE}, 8'h00);
    STOP_MODE <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge REF_CLK);
    RST <= 1'b0;
    t_reset;
    t_eight;
    t_timing;
    t_lock;
    t_modes;
    conclude;
  end
  // Watchdog, well past the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge REF_CLK);
    num_errors++;
    conclude;
  end
endmodule
